// ==== inc/timer_ccm_consts.vh ====
// constants for the channel 3/4 capture/compare mode block
// assumes a 32-bit register bus with word-aligned byte offsets
`ifndef TIMER_CCM_CONSTS_VH
`define TIMER_CCM_CONSTS_VH

// register byte offsets
`define OFF_MODE 8'h00
`define OFF_ENABLE 8'h04
`define OFF_CH3_VALUE 8'h08
`define OFF_CH4_VALUE 8'h0c
`define OFF_STATUS 8'h10

// reset values
`define RST_MODE 16'h0000
`define RST_VALUE 16'h0000

// mode register fields, channel 4 input view
`define F_CH4_FILT 15:12
`define F_CH4_PSC 11:10
`define F_CH4_DIR 9:8
// channel 4 output view
`define F_CH4_OCM 14:12
`define B_CH4_BUF 11
`define B_CH4_FAST 10
// channel 3 input view
`define F_CH3_FILT 7:4
`define F_CH3_PSC 3:2
`define F_CH3_DIR 1:0
// channel 3 output view
`define F_CH3_OCM 6:4
`define B_CH3_BUF 3
`define B_CH3_FAST 2

// enable register bits
`define B_CH3_ON 8
`define B_CH4_ON 12

// status register bits
`define B_CH3_CAP 0
`define B_CH4_CAP 1
`define B_CH3_REF 2
`define B_CH4_REF 3

// direction codes
`define DIR_OUT 2'h0
`define DIR_OWN 2'h1
`define DIR_OTHER 2'h2
`define DIR_TRIG 2'h3

// output compare modes
`define OCM_FROZEN 3'h0
`define OCM_SET 3'h1
`define OCM_CLEAR 3'h2
`define OCM_TOGGLE 3'h3
`define OCM_FORCE_LO 3'h4
`define OCM_FORCE_HI 3'h5
`define OCM_PWM1 3'h6
`define OCM_PWM2 3'h7

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/input_filter.v ====
// input filter, edge detector and capture prescaler for one channel
// assumes sample_in is already synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
`include "timer_ccm_consts.vh"

module input_filter (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // control
  input wire enable,
  input wire [3:0] filter_code,
  input wire [1:0] prescale_code,
  // signal
  input wire sample_in,
  output reg filtered,
  output reg capture_pulse
);

  reg [4:0] div_cnt_reg;
  reg [3:0] run_reg;
  reg [2:0] evt_reg;
  reg [2:0] div_log;
  reg [3:0] need_n;
  reg [4:0] div_mask;
  reg [2:0] evt_limit;
  reg tick;
  reg filt_next;
  reg [3:0] run_next;
  reg rise;

  // filter code to sample-rate divisor and run length
  always @* begin
    case (filter_code)
      4'h0: begin div_log = 3'h0; need_n = 4'h1; end
      4'h1: begin div_log = 3'h0; need_n = 4'h2; end
      4'h2: begin div_log = 3'h0; need_n = 4'h4; end
      4'h3: begin div_log = 3'h0; need_n = 4'h8; end
      4'h4: begin div_log = 3'h1; need_n = 4'h6; end
      4'h5: begin div_log = 3'h1; need_n = 4'h8; end
      4'h6: begin div_log = 3'h2; need_n = 4'h6; end
      4'h7: begin div_log = 3'h2; need_n = 4'h8; end
      4'h8: begin div_log = 3'h3; need_n = 4'h6; end
      4'h9: begin div_log = 3'h3; need_n = 4'h8; end
      4'ha: begin div_log = 3'h4; need_n = 4'h5; end
      4'hb: begin div_log = 3'h4; need_n = 4'h6; end
      4'hc: begin div_log = 3'h4; need_n = 4'h8; end
      4'hd: begin div_log = 3'h5; need_n = 4'h5; end
      4'he: begin div_log = 3'h5; need_n = 4'h6; end
      default: begin div_log = 3'h5; need_n = 4'h8; end
    endcase
  end

  // sample tick, run counter and edge decode
  always @* begin
    div_mask = (5'h01 << div_log) - 5'h01;
    tick = ((div_cnt_reg & div_mask) == 5'h00);
    evt_limit = (3'h1 << prescale_code) - 3'h1;
    filt_next = filtered;
    run_next = run_reg;
    if (tick) begin
      if (sample_in == filtered) begin
        run_next = 4'h0;
      end else if (run_reg + 4'h1 >= need_n) begin
        filt_next = sample_in;
        run_next = 4'h0;
      end else begin
        run_next = run_reg + 4'h1;
      end
    end
    rise = filt_next & ~filtered;
  end

  // filter state and prescaler, held idle while the channel is an output
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 5'h00;
      run_reg <= 4'h0;
      evt_reg <= 3'h0;
      filtered <= 1'b0;
      capture_pulse <= 1'b0;
    end else if (!enable) begin
      div_cnt_reg <= 5'h00;
      run_reg <= 4'h0;
      evt_reg <= 3'h0;
      filtered <= 1'b0;
      capture_pulse <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
      run_reg <= run_next;
      filtered <= filt_next;
      capture_pulse <= 1'b0;
      if (rise) begin
        if (evt_reg >= evt_limit) begin
          evt_reg <= 3'h0;
          capture_pulse <= 1'b1;
        end else begin
          evt_reg <= evt_reg + 3'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/timer_ccm_ch34.v ====
// capture/compare mode logic for timer channels 3 and 4 with an
// AXI4-Lite register slave
// assumes count_value, count_down and update_event come from the timer
// counter on mclk; the three timer inputs are asynchronous pins
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ccm_consts.vh"

// Summary of operation
// - channel 4 filter passes a level after N equal consecutive samples
// - codes 0-3 sample at mclk: no filter, N=2, 4, 8
// - codes 4-9 sample at mclk/2, /4, /8 with N=6 then N=8
// - codes a-c use mclk/16, d-f mclk/32, each with N=5, 6, 8
// - filter and prescale act only while channel 4 is an input
// - channel 4 prescaler captures every rising edge, or each 2, 4, 8 events
// - ch4 direction: 00 output, 01 own input, 10 channel 3 input
// - ch4 direction 11 takes the internal trigger input
// - ch3 compare mode drives its reference like ch4, output only
// - ch3 compare buffer enable works like ch4, output only
// - ch3 fast compare works like ch4, output only
// - ch3 capture prescaler encodes like channel 4
// - ch3 direction: 00 output, 01 own timer input
// - ch3 direction 10 takes channel 4 input, 11 the trigger
// - compare modes: frozen, set, clear, toggle, force lo/hi, pwm1/2
// - buffered compare value loads into the active copy on update
// - fast mode makes a trigger edge act as a match in pwm modes
module timer_ccm_ch34 #(
  parameter CW = 16
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // axi4-lite write address and data
  input wire awvalid,
  output reg awready,
  input wire [7:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // axi4-lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // axi4-lite read
  input wire arvalid,
  output reg arready,
  input wire [7:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // timer pins and trigger
  input wire timer_input_three,
  input wire timer_input_four,
  input wire internal_trigger_input,
  // counter side
  input wire [CW-1:0] count_value,
  input wire count_down,
  input wire update_event,
  // compare references
  output reg ch3_compare_reference,
  output reg ch4_compare_reference
);

  // merge a write into a word under the byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  // pick a channel's capture source from its direction code
  function pick_source;
    input [1:0] dir;
    input own;
    input other;
    input trig;
    begin
      case (dir)
        `DIR_OWN: pick_source = own;
        `DIR_OTHER: pick_source = other;
        `DIR_TRIG: pick_source = trig;
        default: pick_source = 1'b0;
      endcase
    end
  endfunction

  // address is mapped
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFF_MODE) || (a == `OFF_ENABLE) ||
        (a == `OFF_CH3_VALUE) || (a == `OFF_CH4_VALUE) ||
        (a == `OFF_STATUS);
    end
  endfunction

  reg [15:0] mode_reg;
  reg ch3_channel_on;
  reg ch4_channel_on;
  reg [CW-1:0] buf_reg [0:1];
  reg [CW-1:0] shadow_reg [0:1];
  reg [1:0] cap_flag_reg;
  reg [2:0] s1_reg;
  reg [2:0] s2_reg;
  reg trig_prev_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire ti3_s;
  wire ti4_s;
  wire trg_s;
  wire trig_rise;
  wire [1:0] ch3_direction_select;
  wire [1:0] ch4_direction_select;
  wire [1:0] dir [0:1];
  wire [2:0] ocm [0:1];
  wire [1:0] buf_en;
  wire [1:0] fast_en;
  wire [1:0] cap_pulse;
  wire [1:0] ref_now;
  wire do_write;
  wire [31:0] wr_word;
  wire [1:0] ch_on;

  assign ti3_s = s2_reg[0];
  assign ti4_s = s2_reg[1];
  assign trg_s = s2_reg[2];
  assign trig_rise = trg_s & ~trig_prev_reg;
  assign ch3_direction_select = mode_reg[`F_CH3_DIR];
  assign ch4_direction_select = mode_reg[`F_CH4_DIR];
  assign dir[0] = ch3_direction_select;
  assign dir[1] = ch4_direction_select;
  assign ocm[0] = mode_reg[`F_CH3_OCM];
  assign ocm[1] = mode_reg[`F_CH4_OCM];
  assign buf_en = {mode_reg[`B_CH4_BUF], mode_reg[`B_CH3_BUF]};
  assign fast_en = {mode_reg[`B_CH4_FAST], mode_reg[`B_CH3_FAST]};
  assign ch_on = {ch4_channel_on, ch3_channel_on};
  assign do_write = aw_full_reg & w_full_reg & ~bvalid;
  assign wr_word = merge(32'h0, w_data_reg, w_strb_reg);

  // two-flop synchronisers for the pins and trigger
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      trig_prev_reg <= 1'b0;
    end else begin
      s1_reg <= {internal_trigger_input, timer_input_four,
        timer_input_three};
      s2_reg <= s1_reg;
      trig_prev_reg <= trg_s;
    end
  end

  // filter, edge and prescale for each channel
  input_filter u_filt3 (
    .mclk(mclk),
    .rstn(rstn),
    .enable(ch3_direction_select != `DIR_OUT),
    .filter_code(mode_reg[`F_CH3_FILT]),
    .prescale_code(mode_reg[`F_CH3_PSC]),
    .sample_in(pick_source(ch3_direction_select, ti3_s, ti4_s,
      trg_s)),
    .filtered(),
    .capture_pulse(cap_pulse[0])
  );

  input_filter u_filt4 (
    .mclk(mclk),
    .rstn(rstn),
    .enable(ch4_direction_select != `DIR_OUT),
    .filter_code(mode_reg[`F_CH4_FILT]),
    .prescale_code(mode_reg[`F_CH4_PSC]),
    .sample_in(pick_source(ch4_direction_select, ti4_s, ti3_s,
      trg_s)),
    .filtered(),
    .capture_pulse(cap_pulse[1])
  );

  assign ref_now = {ch4_compare_reference, ch3_compare_reference};

  // per-channel compare value, capture and reference logic
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [7:0] off = (g == 0) ? `OFF_CH3_VALUE : `OFF_CH4_VALUE;
      wire is_out = (dir[g] == `DIR_OUT);
      wire match = (count_value == shadow_reg[g]);
      wire lower = (count_value < shadow_reg[g]);
      wire higher = (count_value > shadow_reg[g]);
      wire pwm1 = count_down ? ~higher : lower;
      reg ref_next;

      // buffer and active copy of the compare value
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          buf_reg[g] <= `RST_VALUE;
          shadow_reg[g] <= `RST_VALUE;
        end else begin
          if (!is_out && cap_pulse[g] && ch_on[g]) begin
            buf_reg[g] <= count_value;
          end else if (do_write && aw_addr_reg == off) begin
            buf_reg[g] <= wr_word[CW-1:0];
          end
          if (!is_out || !buf_en[g] || update_event) begin
            shadow_reg[g] <= buf_reg[g];
          end
        end
      end

      // reference level from the compare mode
      always @* begin
        ref_next = ref_now[g];
        case (ocm[g])
          `OCM_FROZEN: ref_next = ref_now[g];
          `OCM_SET: ref_next = match ? 1'b1 : ref_now[g];
          `OCM_CLEAR: ref_next = match ? 1'b0 : ref_now[g];
          `OCM_TOGGLE: ref_next = match ? ~ref_now[g] : ref_now[g];
          `OCM_FORCE_LO: ref_next = 1'b0;
          `OCM_FORCE_HI: ref_next = 1'b1;
          `OCM_PWM1: ref_next = (fast_en[g] && trig_rise) ? 1'b1 : pwm1;
          `OCM_PWM2: ref_next = (fast_en[g] && trig_rise) ? 1'b0 : ~pwm1;
          default: ref_next = ref_now[g];
        endcase
        if (!is_out) begin
          ref_next = 1'b0;
        end
      end
    end
  endgenerate

  // reference outputs; fast mode in pwm acts on the trigger edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch3_compare_reference <= 1'b0;
      ch4_compare_reference <= 1'b0;
    end else begin
      ch3_compare_reference <= chan[0].ref_next;
      ch4_compare_reference <= chan[1].ref_next;
    end
  end

  // mode, enable and capture flag registers
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= `RST_MODE;
      ch3_channel_on <= 1'b0;
      ch4_channel_on <= 1'b0;
      cap_flag_reg <= 2'h0;
    end else begin
      if (do_write && aw_addr_reg == `OFF_MODE) begin
        mode_reg[15:10] <= wr_word[15:10];
        mode_reg[7:2] <= wr_word[7:2];
        if (!ch4_channel_on) begin
          mode_reg[`F_CH4_DIR] <= wr_word[`F_CH4_DIR];
        end
        if (!ch3_channel_on) begin
          mode_reg[`F_CH3_DIR] <= wr_word[`F_CH3_DIR];
        end
      end
      if (do_write && aw_addr_reg == `OFF_ENABLE) begin
        ch3_channel_on <= wr_word[`B_CH3_ON];
        ch4_channel_on <= wr_word[`B_CH4_ON];
      end
      // write one to clear; a new capture in the same cycle wins
      if (do_write && aw_addr_reg == `OFF_STATUS) begin
        cap_flag_reg <= (cap_flag_reg & ~wr_word[1:0]) |
          (cap_pulse & ch_on);
      end else begin
        cap_flag_reg <= cap_flag_reg | (cap_pulse & ch_on);
      end
    end
  end

  // axi write channels: take address and data in either order
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      awready <= ~aw_full_reg & ~awready & awvalid;
      wready <= ~w_full_reg & ~wready & wvalid;
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  // axi read channel: answer one cycle after the address is taken
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= ~arready & ~rvalid & arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `OFF_MODE: rdata <= {16'h0, mode_reg};
          `OFF_ENABLE: rdata <= {19'h0, ch4_channel_on, 3'h0,
            ch3_channel_on, 8'h0};
          `OFF_CH3_VALUE: rdata <= {{(32-CW){1'b0}}, buf_reg[0]};
          `OFF_CH4_VALUE: rdata <= {{(32-CW){1'b0}}, buf_reg[1]};
          `OFF_STATUS: rdata <= {28'h0, ch4_compare_reference,
            ch3_compare_reference, cap_flag_reg};
          default: rdata <= 32'h0;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/timer_pins_model.sv ====
// pin and trigger driver standing in for the world outside the timer
// assumes the block samples these levels through its own synchronisers
`timescale 1ns/1ps
`default_nettype none
module timer_pins_model (
  // clock
  input wire logic mclk,
  // levels toward the block
  output logic pin_three,
  output logic pin_four,
  output logic trig
);
  logic [2:0] lvl = 3'h0;
  // all three sources idle low between pulses
  assign pin_three = lvl[0];
  assign pin_four = lvl[1];
  assign trig = lvl[2];
  // raise one source for len cycles, changed just after an edge
  task automatic pulse(input int sel, input int len);
    @(posedge mclk);
    lvl[sel] <= 1'b1;
    repeat (len) @(posedge mclk);
    lvl[sel] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/timer_ccm_ch34_properties.sv ====
// register bus checker for the channel 3/4 mode block
// assumes it is bound into every timer_ccm_ch34 instance
`timescale 1ns/1ps
`default_nettype none
module timer_ccm_ch34_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // read side
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  aw_pulse_a: assert property (awready |=> !awready)
    else $error("awready held past one cycle");
  w_pulse_a: assert property (wready |=> !wready)
    else $error("wready held past one cycle");
  b_answer_a: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write response late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  ar_cause_a: assert property ($rose(arready) |-> $past(arvalid))
    else $error("arready without request");
  bad_write_a: assert property (awvalid && awready && awaddr > 8'h10
    |-> ##[1:3] bvalid && bresp == 2'h2) else $error("no write error");
  bad_read_a: assert property (arvalid && arready && araddr > 8'h10
    |=> rresp == 2'h2 && rdata == 32'h0) else $error("no read error");
  no_pend_a: assert property (bvalid |-> !awready)
    else $error("address taken with response pending");
endmodule
bind timer_ccm_ch34 timer_ccm_ch34_properties u_props (
  .mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
  .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp));
`default_nettype wire

// ==== testbench/timer_ch3_ch4_mode_config_bench.sv ====
// self-checking bench for the channel 3/4 capture/compare mode block
// assumes the pin model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module timer_ch3_ch4_mode_config_bench;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready, upd, cdown;
  logic awready, wready, bvalid, arready, rvalid, t3, t4, trg, ref3, ref4;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs_v;
  logic [15:0] cval;
  logic [31:0] reg_m [4];
  logic seen;
  int err_count, num_checks, seed, cnt, want;
  int nlen [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  timer_ccm_ch34 #(.CW(16)) u_dut (
    .mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timer_input_three(t3), .timer_input_four(t4),
    .internal_trigger_input(trg), .count_value(cval), .count_down(cdown),
    .update_event(upd), .ch3_compare_reference(ref3),
    .ch4_compare_reference(ref4));
  timer_pins_model u_pins (.mclk(mclk), .pin_three(t3), .pin_four(t4),
    .trig(trg));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // compare tasks, one per kind of result
  task automatic chk_word(input string w, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_resp(input string w, input logic [1:0] e, g);
    chk_word(w, {30'h0, e}, {30'h0, g});
  endtask
  task automatic chk_bit(input string w, input logic e, g);
    chk_word(w, {31'h0, e}, {31'h0, g});
  endtask
  // bus write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge mclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (!bvalid && k < 100);
    r = bresp;
    bready <= 1'b0;
    if (k >= 100) err_count++;
  endtask
  // bus read, rready held until the data comes
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int k;
    k = 0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (!rvalid && k < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k >= 100) err_count++;
  endtask
  // write a register and update the model image
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    logic [31:0] v;
    wr(a, d, 4'hf, r);
    chk_resp("bresp", 2'h0, r);
    v = d & (a == 8'h04 ? 32'h1100 : 32'hffff);
    if (a == 8'h00 && reg_m[1][8]) v[1:0] = reg_m[0][1:0];
    if (a == 8'h00 && reg_m[1][12]) v[9:8] = reg_m[0][9:8];
    if (a < 8'h10) reg_m[a[3:2]] = v;
  endtask
  task automatic get(input logic [7:0] a);
    rd(a, rd_v, rs_v);
    chk_resp("rresp", 2'h0, rs_v);
    chk_word("register", reg_m[a[3:2]], rd_v);
  endtask
  // one pulse on a source, then the capture flag of channel ch
  task automatic cap(input int ch, src, len, input logic e);
    put(8'h10, 32'h3);
    u_pins.pulse(src, len);
    repeat (2 * len + 40) @(posedge mclk);
    rd(8'h10, rd_v, rs_v);
    chk_bit("capture flag", e, rd_v[ch-3]);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog, well past the expected run length
  initial begin
    #500000;
    err_count++;
    close_out;
  end
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, upd, cdown} = 7'h0;
    {awaddr, araddr, wdata, wstrb, cval} = '0;
    reg_m = '{default: 32'h0};
    seed = 81;
    rstn = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) get(8'(i * 4));
    for (int i = 0; i < 4; i++) begin
      put(8'(i * 4), $random(seed));
      get(8'(i * 4));
    end
    put(8'h04, 32'h0);
    wr(8'h00, 32'hffffffff, 4'h1, rs_v);
    reg_m[0] = 32'hff;
    get(8'h00);
    wr(8'h14, 32'h1, 4'hf, rs_v);
    chk_resp("unmapped bresp", 2'h2, rs_v);
    rd(8'h20, rd_v, rs_v);
    chk_resp("unmapped rresp", 2'h2, rs_v);
    put(8'h04, 32'h1100);
    put(8'h00, 32'h0302);
    get(8'h00);
    $display("test registers done");
    put(8'h04, 32'h0);
    put(8'h00, 32'h100);
    put(8'h04, 32'h1000);
    for (int c = 0; c < 16; c++) begin
      want = c < 4 ? 1 : c < 10 ? 2 << ((c - 4) / 2) : c < 13 ? 16 : 32;
      put(8'h00, (c << 12) | 32'h100);
      if (nlen[c] > 2) cap(4, 1, want * (nlen[c] - 2), 1'b0);
      cap(4, 1, want * (nlen[c] + 2) + 4, 1'b1);
    end
    $display("test filter done");
    for (int p = 0; p < 4; p++) begin
      put(8'h00, (p << 10) | 32'h100);
      cnt = 0;
      for (int e = 0; e < 8; e++) begin
        put(8'h10, 32'h3);
        u_pins.pulse(1, 4);
        repeat (20) @(posedge mclk);
        rd(8'h10, rd_v, rs_v);
        cnt += rd_v[1];
      end
      chk_word("capture count", 8 >> p, cnt);
    end
    $display("test prescale done");
    for (int ch = 3; ch < 5; ch++)
      for (int d = 0; d < 4; d++)
        for (int s = 0; s < 3; s++) begin
          want = d == 3 ? 2 : ((d == 1) == (ch == 4) ? 1 : 0);
          put(8'h04, 32'h0);
          put(8'h00, d << (ch == 3 ? 0 : 8));
          put(8'h04, ch == 3 ? 32'h100 : 32'h1000);
          cap(ch, s, 6, d != 0 && s == want);
        end
    $display("test direction done");
    put(8'h04, 32'h0);
    put(8'h08, 32'ha);
    cval <= 16'ha;
    for (int m = 0; m < 8; m++) begin
      put(8'h00, 32'h40);
      put(8'h00, m << 4);
      repeat (4) @(posedge mclk);
      if (m != 3) chk_bit("ch3 reference", 8'ha2 >> m, ref3);
      else begin
        seen = ref3;
        @(posedge mclk);
        chk_bit("toggle ref", ~seen, ref3);
      end
    end
    put(8'h00, 32'h68);
    cval <= 16'h32;
    put(8'h08, 32'h64);
    repeat (4) @(posedge mclk);
    chk_bit("buffered ref", 1'b0, ref3);
    upd <= 1'b1;
    @(posedge mclk);
    upd <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_bit("loaded ref", 1'b1, ref3);
    cval <= 16'h78;
    for (int f = 0; f < 2; f++) begin
      put(8'h00, 32'h60 | (f << 2));
      seen = 1'b0;
      fork
        u_pins.pulse(2, 4);
        repeat (8) @(posedge mclk) seen |= ref3;
      join
      chk_bit("fast ref", f[0], seen);
    end
    // pwm1 at equality: active when counting down, inactive counting up
    cval <= 16'h64;
    cdown <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_bit("down ref", 1'b1, ref3);
    cdown <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_bit("up ref", 1'b0, ref3);
    put(8'h00, 32'h51);
    repeat (4) @(posedge mclk);
    chk_bit("input ch3 ref", 1'b0, ref3);
    put(8'h00, 32'h5000);
    repeat (4) @(posedge mclk);
    chk_bit("ch4 reference", 1'b1, ref4);
    $display("test compare done");
    close_out;
  end
endmodule
`default_nettype wire
